// File: mcrtc_pkg.sv
package mcrtc_pkg;

   // Register map
   localparam logic [7:0] CSR_ADDR = 8'h2C;
   localparam logic [7:0] BEEP_ADDR = 8'h2D;
   localparam logic [7:0] RD_IDLE = 8'h00;

   // Field positions
   localparam int MCO_POS = 7;
   localparam int CP_LSB = 5;
   localparam int SMS_POS = 4;
   localparam int TB_LSB = 2;
   localparam int OIE_POS = 1;
   localparam int OIF_POS = 0;
   localparam int TONE_LSB = 0;

   // Reset values
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] BEEP_RESET = 8'h00;

   // Time-base periods in oscillator cycles
   localparam int TB_PERIOD_00 = 16000;
   localparam int TB_PERIOD_01 = 32000;
   localparam int TB_PERIOD_10 = 80000;
   localparam int TB_PERIOD_11 = 200000;
   localparam int TB_CNT_W = 18;

   // Tone half periods derived from the reference oscillator
   localparam int OSC_REF_HZ = 8000000;
   localparam int TONE_HZ_01 = 2000;
   localparam int TONE_HZ_10 = 1000;
   localparam int TONE_HZ_11 = 500;
   localparam int TONE_HALF_01 = OSC_REF_HZ / (2 * TONE_HZ_01);
   localparam int TONE_HALF_10 = OSC_REF_HZ / (2 * TONE_HZ_10);
   localparam int TONE_HALF_11 = OSC_REF_HZ / (2 * TONE_HZ_11);
   localparam int TONE_CNT_W = 13;

   // Slow-mode divider terminal counts (ratio minus one)
   localparam logic [3:0] DIV_TERM_00 = 4'h1;
   localparam logic [3:0] DIV_TERM_01 = 4'h3;
   localparam logic [3:0] DIV_TERM_10 = 4'h7;
   localparam logic [3:0] DIV_TERM_11 = 4'hF;

   // Power modes of the core as seen by this block
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_WAIT = 2'b01,
      MODE_AHALT = 2'b10,
      MODE_HALT = 2'b11
   } mcrtc_mode_e;

endpackage

// File: mcrtc_timebase.sv
`timescale 1ns/1ns
module mcrtc_timebase
   import mcrtc_pkg::*;
#(
   parameter int PERIOD_00 = TB_PERIOD_00,
   parameter int PERIOD_01 = TB_PERIOD_01,
   parameter int PERIOD_10 = TB_PERIOD_10,
   parameter int PERIOD_11 = TB_PERIOD_11
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic clk_en,
   input wire logic run,
   input wire logic [1:0] period_select,
   // Period elapsed, combinational
   output logic wrap
);

   logic [TB_CNT_W-1:0] count_reg;
   logic [1:0] active_sel_reg;
   logic hit;

   function automatic logic [TB_CNT_W-1:0] last_count(input logic [1:0] sel);
      case (sel)
         2'b00: last_count = TB_CNT_W'(PERIOD_00 - 1);
         2'b01: last_count = TB_CNT_W'(PERIOD_01 - 1);
         2'b10: last_count = TB_CNT_W'(PERIOD_10 - 1);
         default: last_count = TB_CNT_W'(PERIOD_11 - 1);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Terminal compare against the period latched at the last wrap
   assign hit = (count_reg == last_count(active_sel_reg));
   assign wrap = run & hit;

   // Counter; the selection is only sampled on wrap so no period is cut short
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= '0;
         active_sel_reg <= CSR_RESET[TB_LSB +: 2];
      end else if (clk_en && run) begin
         if (hit) begin
            count_reg <= '0;
            active_sel_reg <= period_select;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   period_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (active_sel_reg != $past(active_sel_reg)) |-> $past(wrap && clk_en))
      else $error("period selection changed mid-period");

   count_range_a: assert property (@(posedge clk) disable iff (!rst_b)
      count_reg <= last_count(active_sel_reg))
      else $error("time-base counter passed its terminal count");

endmodule // mcrtc_timebase

// File: mcrtc_tone.sv
`timescale 1ns/1ns
module mcrtc_tone
   import mcrtc_pkg::*;
#(
   parameter int HALF_01 = TONE_HALF_01,
   parameter int HALF_10 = TONE_HALF_10,
   parameter int HALF_11 = TONE_HALF_11
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic clk_en,
   input wire logic run,
   input wire logic [1:0] tone_select,
   // Pin
   output logic tone_o,
   output logic tone_oe
);

   logic [TONE_CNT_W-1:0] cnt_reg;
   logic [1:0] sel_prev_reg;
   logic tone_reg;
   logic oe_reg;
   logic [TONE_CNT_W-1:0] half_last;
   logic tone_on;
   logic restart;

   ////////////////////////////////////////////////////////////////////////////
   // Half-period select; code zero switches the tone off
   assign half_last = (tone_select == 2'b01) ? TONE_CNT_W'(HALF_01 - 1) :
                      (tone_select == 2'b10) ? TONE_CNT_W'(HALF_10 - 1) :
                      TONE_CNT_W'(HALF_11 - 1);
   assign tone_on = (tone_select != 2'b00);
   assign restart = (tone_select != sel_prev_reg); // Clean start on a new pitch
   assign tone_o = tone_reg;
   assign tone_oe = oe_reg;

   // Square wave, about half duty; frozen only in full halt
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         sel_prev_reg <= BEEP_RESET[TONE_LSB +: 2];
         tone_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (clk_en && run) begin
         sel_prev_reg <= tone_select;
         oe_reg <= tone_on;
         if (!tone_on || restart) begin
            cnt_reg <= '0;
            tone_reg <= 1'b0;
         end else if (cnt_reg == half_last) begin
            cnt_reg <= '0;
            tone_reg <= ~tone_reg;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   tone_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && run && !tone_on) |=> (!tone_reg && !oe_reg))
      else $error("tone not silent with code zero");

endmodule // mcrtc_tone

// File: mcrtc_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module mcrtc_top
   import mcrtc_pkg::*;
#(
   parameter int TB_P00 = TB_PERIOD_00,
   parameter int TB_P01 = TB_PERIOD_01,
   parameter int TB_P10 = TB_PERIOD_10,
   parameter int TB_P11 = TB_PERIOD_11,
   parameter int TONE_H01 = TONE_HALF_01,
   parameter int TONE_H10 = TONE_HALF_10,
   parameter int TONE_H11 = TONE_HALF_11
)(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // Core handshake
   input wire logic wait_exec,
   input wire logic halt_exec,
   input wire logic int_mask,
   input wire logic ext_wake,
   output logic timebase_irq,
   output logic cpu_tick,
   output logic [1:0] power_mode,
   // Pins
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe,
   output logic tone_pin_o,
   output logic tone_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic rst_b_meta_reg;
   logic rst_b_sync_reg;

   logic [7:1] csr_ctrl_reg;
   logic timebase_elapsed_flag_reg;
   logic [1:0] beep_reg;
   logic [7:0] rd_data_reg;

   mcrtc_mode_e mode_reg;
   mcrtc_mode_e mode_next;

   logic [3:0] div_cnt_reg;
   logic cpu_tick_reg;
   logic clk_out_reg;
   logic clk_out_oe_reg;
   logic timebase_irq_reg;

   logic cpu_clock_output_enable;
   logic [1:0] slow_divider_select;
   logic slow_speed_select;
   logic [1:0] period_select;
   logic timebase_irq_enable;
   logic [1:0] tone_select;

   logic csr_hit;
   logic beep_hit;
   logic halted;
   logic cpu_run;
   logic wr_ok;
   logic csr_wr;
   logic beep_wr;
   logic csr_rd;
   logic tb_wrap;
   logic tb_run;
   logic flag_next;
   logic irq_req;
   logic [3:0] div_term;
   logic div_last;
   logic [7:0] csr_view;
   logic [7:0] beep_view;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release; assertion is immediate, release waits two edges

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_b_meta_reg <= 1'b0;
         rst_b_sync_reg <= 1'b0;
      end else begin
         rst_b_meta_reg <= 1'b1;
         rst_b_sync_reg <= rst_b_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field views of the control register

   assign cpu_clock_output_enable = csr_ctrl_reg[MCO_POS];
   assign slow_divider_select = csr_ctrl_reg[CP_LSB +: 2];
   assign slow_speed_select = csr_ctrl_reg[SMS_POS];
   assign period_select = csr_ctrl_reg[TB_LSB +: 2];
   assign timebase_irq_enable = csr_ctrl_reg[OIE_POS];
   assign tone_select = beep_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and access qualifiers

   assign csr_hit = (addr == CSR_ADDR);
   assign beep_hit = (addr == BEEP_ADDR);
   // The core cannot write while its clock is stopped, so writes are ignored
   assign halted = (mode_reg == MODE_AHALT) || (mode_reg == MODE_HALT);
   assign cpu_run = !halted;
   assign wr_ok = clk_en && wr_en && !halted;
   assign csr_wr = wr_ok && csr_hit;
   assign beep_wr = wr_ok && beep_hit;
   // A read of the status register is what clears the flag; bit ops must avoid it
   assign csr_rd = clk_en && rd_en && csr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Read data; unmapped addresses and reserved bits read zero

   assign csr_view = {csr_ctrl_reg, timebase_elapsed_flag_reg};
   assign beep_view = {6'h00, beep_reg};
   always_comb begin
      if (csr_hit) begin
         rd_mux = csr_view;
      end else if (beep_hit) begin
         rd_mux = beep_view;
      end else begin
         rd_mux = RD_IDLE;
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         rd_data_reg <= RD_IDLE;
      end else if (clk_en) begin
         rd_data_reg <= rd_en ? rd_mux : RD_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; reserved tone bits are dropped on write

   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         csr_ctrl_reg <= CSR_RESET[7:1];
         beep_reg <= BEEP_RESET[TONE_LSB +: 2];
      end else begin
         if (csr_wr) begin
            csr_ctrl_reg <= wr_data[7:1];
         end
         if (beep_wr) begin
            beep_reg <= wr_data[TONE_LSB +: 2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Elapsed flag; a wrap in the reading cycle survives the clear

   assign flag_next = tb_wrap || (timebase_elapsed_flag_reg && !csr_rd);
   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         timebase_elapsed_flag_reg <= CSR_RESET[OIF_POS];
      end else if (clk_en) begin
         timebase_elapsed_flag_reg <= flag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request to the core, also the wake source

   assign irq_req = timebase_elapsed_flag_reg && timebase_irq_enable && !int_mask;
   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         timebase_irq_reg <= 1'b0;
      end else if (clk_en) begin
         timebase_irq_reg <= irq_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power mode tracking

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN: begin
            if (halt_exec) begin
               mode_next = timebase_irq_enable ? MODE_AHALT : MODE_HALT;
            end else if (wait_exec) begin
               mode_next = MODE_WAIT;
            end
         end
         MODE_WAIT, MODE_AHALT: begin
            if (irq_req || ext_wake) begin
               mode_next = MODE_RUN;
            end
         end
         MODE_HALT: begin
            // Only an external wake; the time-base is stopped anyway
            if (ext_wake) begin
               mode_next = MODE_RUN;
            end
         end
         default: begin
            mode_next = MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         mode_reg <= MODE_RUN;
      end else if (clk_en) begin
         mode_reg <= mode_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU clock as a tick; divide by one costs no counter

   assign div_term = (slow_divider_select == 2'b00) ? DIV_TERM_00 :
                     (slow_divider_select == 2'b01) ? DIV_TERM_01 :
                     (slow_divider_select == 2'b10) ? DIV_TERM_10 : DIV_TERM_11;
   assign div_last = !slow_speed_select || (div_cnt_reg == div_term);

   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         div_cnt_reg <= 4'h0;
         cpu_tick_reg <= 1'b0;
      end else if (clk_en) begin
         div_cnt_reg <= (!cpu_run || div_last) ? 4'h0 : div_cnt_reg + 4'h1;
         cpu_tick_reg <= cpu_run && div_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock-out pin; toggles per tick, so it shows half the tick rate

   always_ff @(posedge clk or negedge rst_b_sync_reg) begin
      if (!rst_b_sync_reg) begin
         clk_out_reg <= 1'b0;
         clk_out_oe_reg <= 1'b0;
      end else if (clk_en) begin
         clk_out_oe_reg <= cpu_clock_output_enable && cpu_run;
         if (!cpu_clock_output_enable || !cpu_run) begin
            clk_out_reg <= 1'b0;
         end else if (cpu_tick_reg) begin
            clk_out_reg <= ~clk_out_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time-base and tone, both stopped only in full halt

   assign tb_run = (mode_reg != MODE_HALT);

   mcrtc_timebase #(
      .PERIOD_00(TB_P00),
      .PERIOD_01(TB_P01),
      .PERIOD_10(TB_P10),
      .PERIOD_11(TB_P11)
   ) u_timebase (
      .clk(clk),
      .rst_b(rst_b_sync_reg),
      .clk_en(clk_en),
      .run(tb_run),
      .period_select(period_select),
      .wrap(tb_wrap)
   );

   mcrtc_tone #(
      .HALF_01(TONE_H01),
      .HALF_10(TONE_H10),
      .HALF_11(TONE_H11)
   ) u_tone (
      .clk(clk),
      .rst_b(rst_b_sync_reg),
      .clk_en(clk_en),
      .run(tb_run),
      .tone_select(tone_select),
      .tone_o(tone_pin_o),
      .tone_oe(tone_pin_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rd_data = rd_data_reg;
   assign timebase_irq = timebase_irq_reg;
   assign cpu_tick = cpu_tick_reg;
   assign power_mode = mode_reg;
   assign clock_out_pin_o = clk_out_reg;
   assign clock_out_pin_oe = clk_out_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b_sync_reg);

   irq_gate_a: assert property (
      clk_en |=> (timebase_irq_reg == $past(timebase_elapsed_flag_reg && timebase_irq_enable && !int_mask)))
      else $error("interrupt request does not follow flag, enable and mask");

   halt_hold_a: assert property (
      (mode_reg == MODE_HALT && !ext_wake) |=> (mode_reg == MODE_HALT))
      else $error("full halt left without external wake");

   halt_select_a: assert property (
      (clk_en && mode_reg == MODE_RUN && halt_exec) |=>
      (mode_reg == ($past(timebase_irq_enable) ? MODE_AHALT : MODE_HALT)))
      else $error("halt entered the wrong mode");

   clkout_free_a: assert property (
      (clk_en && !cpu_clock_output_enable) |=> (!clk_out_oe_reg && !clk_out_reg))
      else $error("clock-out pin driven while disabled");

   clkout_suspend_a: assert property (
      (clk_en && mode_reg == MODE_AHALT) |=> (!clk_out_oe_reg && !clk_out_reg))
      else $error("clock-out active in active-halt");

   normal_tick_a: assert property (
      (clk_en && !slow_speed_select && cpu_run) |=> cpu_tick_reg)
      else $error("normal mode missed a cpu tick");

   slow_gap_a: assert property (
      (clk_en && cpu_tick_reg && slow_speed_select && slow_divider_select == 2'b11 && cpu_run)
      |=> !cpu_tick_reg [*8])
      else $error("slow divide by sixteen ticked too soon");

   flag_set_a: assert property (
      (clk_en && tb_wrap) |=> timebase_elapsed_flag_reg)
      else $error("wrap lost, even against a read");

   flag_clear_a: assert property (
      (clk_en && csr_rd && !tb_wrap) |=> !timebase_elapsed_flag_reg)
      else $error("status read did not clear the flag");

   halt_freeze_a: assert property (
      (mode_reg == MODE_HALT) |=> ($stable(csr_ctrl_reg) && $stable(beep_reg)))
      else $error("registers changed in full halt");

   reset_clear_a: assert property (
      $rose(rst_b_sync_reg) |-> (csr_view == CSR_RESET && beep_view == BEEP_RESET))
      else $error("registers not cleared by reset");

endmodule // mcrtc_top

// File: mcrtc_top_tb_top.sv
`timescale 1ns/1ns
module mcrtc_top_tb_top import mcrtc_pkg::*;;

   // Shortened counts keep the run brief
   localparam int PER [4] = '{20, 30, 40, 50};
   localparam int HALF [4] = '{0, 3, 5, 7};
   localparam int ORD [3] = '{3, 1, 2};

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic wait_exec = 1'b0;
   logic halt_exec = 1'b0;
   logic int_mask = 1'b0;
   logic ext_wake = 1'b0;
   logic [7:0] rd_data;
   logic timebase_irq;
   logic cpu_tick;
   logic [1:0] power_mode;
   logic clock_out_pin_o;
   logic clock_out_pin_oe;
   logic tone_pin_o;
   logic tone_pin_oe;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0, t1, k, n, m;
   logic [7:0] d;
   logic [7:0] csr_val;

   mcrtc_top #(.TB_P00(PER[0]), .TB_P01(PER[1]), .TB_P10(PER[2]), .TB_P11(PER[3]),
      .TONE_H01(HALF[1]), .TONE_H10(HALF[2]), .TONE_H11(HALF[3])) dut (
      .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .wait_exec(wait_exec), .halt_exec(halt_exec),
      .int_mask(int_mask), .ext_wake(ext_wake), .timebase_irq(timebase_irq), .cpu_tick(cpu_tick),
      .power_mode(power_mode), .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe(clock_out_pin_oe),
      .tone_pin_o(tone_pin_o), .tone_pin_oe(tone_pin_oe));

   // 100 MHz clock and a cycle stamp for interval measurement
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      v = rd_data;
   endtask

   // Core pulse: 0 halt, 1 wait, 2 external wake
   task automatic core(input int w);
      @(posedge clk);
      {ext_wake, wait_exec, halt_exec} <= 3'(1 << w);
      @(posedge clk);
      {ext_wake, wait_exec, halt_exec} <= 3'b000;
   endtask

   // Waits for a fresh request, stamps it, then clears the flag by reading
   task automatic wait_irq(output int t);
      int i;
      i = 0;
      while (timebase_irq !== 1'b0 && i < 300) begin
         @(negedge clk);
         i++;
      end
      while (timebase_irq !== 1'b1 && i < 600) begin
         @(negedge clk);
         i++;
      end
      if (i >= 600) check("irq wait", 0, 1);
      t = cyc;
      rd(CSR_ADDR, d);
      check("flag set", d, csr_val | 8'h01);
      rd(CSR_ADDR, d);
      check("flag cleared", d, csr_val);
   endtask

   // Length of the third tone half period, skipping the restart
   task automatic tone_half(output int h);
      logic last;
      int i;
      @(negedge clk);
      for (int j = 0; j < 3; j++) begin
         last = tone_pin_o;
         i = 0;
         do begin
            @(negedge clk);
            i++;
         end while (tone_pin_o === last && i < 100);
      end
      h = i;
   endtask

   task automatic count_ticks(input int cycles, output int nt, output int ntog);
      logic last;
      nt = 0;
      ntog = 0;
      last = clock_out_pin_o;
      repeat (cycles) begin
         @(negedge clk);
         if (cpu_tick === 1'b1) nt++;
         if (clock_out_pin_o !== last) ntog++;
         last = clock_out_pin_o;
      end
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Tests

   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      // Reads land before the first period can end
      rd(CSR_ADDR, d);
      check("csr reset", d, CSR_RESET);
      rd(BEEP_ADDR, d);
      check("beep reset", d, BEEP_RESET);
      rd(8'h2E, d);
      check("unmapped", d, RD_IDLE);
      check("pins reset", {power_mode, clock_out_pin_oe, tone_pin_oe}, 4'h0);
      $display("test reset done");
      // Software keeps the reserved tone bits at zero
      wr(BEEP_ADDR, 8'h01);
      rd(BEEP_ADDR, d);
      check("beep reserved", d, 8'h01);
      for (int c = 1; c < 4; c++) begin
         wr(BEEP_ADDR, 8'(c));
         tone_half(k);
         check("tone half", k, HALF[c]);
         check("tone oe", tone_pin_oe, 1'b1);
      end
      wr(BEEP_ADDR, 8'h00);
      repeat (3) @(negedge clk);
      check("tone off", tone_pin_oe, 1'b0);
      $display("test tone done");
      // Normal speed, then every slow divider, clock out enabled
      wr(CSR_ADDR, 8'h80);
      repeat (20) @(negedge clk);
      count_ticks(64, n, m);
      check("normal ticks", n, 64);
      check("clkout toggles", m, 64);
      check("clkout oe", clock_out_pin_oe, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(CSR_ADDR, 8'h90 | 8'(c << 5));
         repeat (40) @(negedge clk);
         count_ticks(64, n, m);
         check("slow ticks", n, 64 >> (c + 1));
         check("slow toggles", m, 64 >> (c + 1));
      end
      wr(CSR_ADDR, 8'h00);
      repeat (3) @(negedge clk);
      check("clkout off", clock_out_pin_oe, 1'b0);
      $display("test cpu clock done");
      // First request may carry a stale flag, so two syncs
      csr_val = 8'h02;
      wr(CSR_ADDR, csr_val);
      wait_irq(t0);
      wait_irq(t0);
      wait_irq(t1);
      check("period", t1 - t0, PER[0]);
      // Selection changed mid-period, in slow mode so the divider must not matter
      k = 0;
      for (int i = 0; i < 3; i++) begin
         csr_val = 8'h72 | 8'(ORD[i] << 2);
         wr(CSR_ADDR, csr_val);
         wait_irq(t0);
         check("old period", t0 - t1, PER[k]);
         wait_irq(t1);
         check("new period", t1 - t0, PER[ORD[i]]);
         k = ORD[i];
      end
      $display("test time base done");
      // Global mask holds the request back while the flag stays pending
      @(posedge clk);
      int_mask <= 1'b1;
      k = 0;
      repeat (60) begin
         @(negedge clk);
         if (timebase_irq !== 1'b0) k++;
      end
      check("masked irq", k, 0);
      @(posedge clk);
      int_mask <= 1'b0;
      repeat (3) @(negedge clk);
      check("unmasked irq", timebase_irq, 1'b1);
      // Clear the pending flag so the next wait starts clean
      rd(CSR_ADDR, d);
      check("pending flag", d, csr_val | 8'h01);
      $display("test mask done");
      // Wait mode left by the time-base request; whole-byte writes, no bit ops
      csr_val = 8'h02;
      wr(CSR_ADDR, csr_val);
      wait_irq(t0);
      core(1);
      @(negedge clk);
      check("wait mode", power_mode, MODE_WAIT);
      wait_irq(t1);
      check("wake from wait", power_mode, MODE_RUN);
      // Active halt: clock out stops, tone keeps going, request wakes
      csr_val = 8'h86;
      wr(CSR_ADDR, csr_val);
      wr(BEEP_ADDR, 8'h01);
      wait_irq(t0);
      core(0);
      repeat (3) @(negedge clk);
      check("active halt", power_mode, MODE_AHALT);
      check("clkout halted", clock_out_pin_oe, 1'b0);
      check("tick halted", cpu_tick, 1'b0);
      tone_half(k);
      check("tone in halt", k, HALF[1]);
      check("still halted", power_mode, MODE_AHALT);
      wait_irq(t1);
      check("wake ahalt", power_mode, MODE_RUN);
      // Full halt freezes counter and tone until an external wake
      csr_val = 8'h00;
      wr(CSR_ADDR, csr_val);
      core(0);
      repeat (3) @(negedge clk);
      check("full halt", power_mode, MODE_HALT);
      m = tone_pin_o;
      k = 0;
      repeat (100) begin
         @(negedge clk);
         if (tone_pin_o !== m[0]) k++;
      end
      check("tone frozen", k, 0);
      check("halt kept", power_mode, MODE_HALT);
      core(2);
      @(negedge clk);
      check("wake halt", power_mode, MODE_RUN);
      rd(CSR_ADDR, d);
      check("counter frozen", d, 8'h00);
      // Clock enable low freezes tone and time base alike
      @(posedge clk);
      clk_en <= 1'b0;
      @(negedge clk);
      m = tone_pin_o;
      k = 0;
      repeat (40) begin
         @(negedge clk);
         if (tone_pin_o !== m[0]) k++;
      end
      check("enable freeze", k, 0);
      @(posedge clk);
      clk_en <= 1'b1;
      rd(CSR_ADDR, d);
      check("enable freeze flag", d, 8'h00);
      $display("test power modes done");
      conclude;
   end

   // Whole run is under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude;
   end

endmodule // mcrtc_top_tb_top
